// ---- pkg/swpc_pkg.sv ----
/*
  Package for the sleep and wake power sequencer: register offsets, field positions,
  reset values, timing counts, sequencer states and the supply configuration carrier.
  Assumes a 10 MHz system clock and a 32-bit AXI4-Lite register bus.
*/
package swpc_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_WAKE_LOW = 8'h04;
  localparam logic [7:0] OFS_WAKE_HIGH = 8'h08;
  localparam logic [7:0] OFS_AWAKE_SUPPLY = 8'h18;
  localparam logic [7:0] OFS_SLEEP1_SUPPLY = 8'h1c;
  localparam logic [7:0] OFS_STATUS = 8'h24;

  // General control field positions
  localparam int CTL_USB_UP = 9;
  localparam int CTL_USB_DOWN = 8;
  localparam int CTL_POR_LEVELS = 7;
  localparam int CTL_REAPPLY = 6;
  localparam int CTL_TIMER64 = 5;
  localparam int CTL_TIMER_WAKE = 4;
  localparam int CTL_PIN_POL = 3;
  localparam int CTL_PIN_WAKE = 2;
  localparam int CTL_SLEEP_GO = 1;
  localparam int CTL_CLK_SEL = 0;
  localparam logic [31:0] CTL_RESET = 32'h0000_0008;
  localparam logic [31:0] CTL_RW_MASK = 32'h0000_03bd;

  // Supply register field positions
  localparam int SUP_TILE_CLK_OFF = 14;
  localparam int SUP_ANALOGUE_PFM = 9;
  localparam int SUP_CORE_PFM = 8;
  localparam int SUP_IO_EN = 5;
  localparam int SUP_PLL_EN = 4;
  localparam int SUP_ANALOGUE_EN = 1;
  localparam int SUP_CORE_EN = 0;
  localparam int SUP_DWELL_LSB = 16;
  localparam int SUP_DWELL_W = 16;
  localparam logic [31:0] AWAKE_RESET = 32'h0000_0033;
  localparam logic [31:0] AWAKE_RW_MASK = 32'h0000_4331;
  localparam logic [31:0] SLEEP1_RESET = 32'h0010_0002;
  localparam logic [31:0] SLEEP1_RW_MASK = 32'hffff_4331;

  // Status field positions
  localparam int STA_PREV_IO = 29;
  localparam int STA_PREV_PLL = 28;
  localparam int STA_PREV_ANALOGUE = 25;
  localparam int STA_PREV_CORE = 24;
  localparam int STA_STATE_LSB = 16;

  // Timing of each fixed waking and sleeping step
  localparam int CLK_PERIOD_NS = 100;
  localparam int STEP_TIME_NS = 1000;
  localparam int STEP_CYCLES = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Sequencer states, reported by their position in this list
  typedef enum logic [2:0] {
    ST_RESET, ST_ASLEEP, ST_WAKING1, ST_WAKING2, ST_AWAKE_WAIT, ST_AWAKE, ST_STATE_SLEEP_ENTRY_ONE, ST_SLEEPING2
  } swpc_state_t;

  // Supply configuration applied to the regulators
  typedef struct packed {
    logic tile_clk_off;
    logic analogue_pfm;
    logic core_pfm;
    logic io_supply_output_en;
    logic pll_supply_regulator_en;
    logic analogue_supply_converter_en;
    logic core_supply_converter_en;
  } swpc_supply_t;

endpackage

// ---- rtl/swpc_sequencer.sv ----
/*
  Sleep and wake power sequencer with its AXI4-Lite register file.
  Assumes TIMER_VALUE is a free-running count on CLK_SYS and WAKE_PIN is asynchronous.
*/
// Register access over AXI4-Lite was chosen for this implementation.
// Function
// - Control bit 9 set puts the USB suspend controller in power-up enable.
// - Control bit 8 set puts the USB suspend controller in power-down enable.
// - Bit 7 clear uses stored levels on wake; set uses power-on levels.
// - Writing 1 to bit 6 re-applies the awake supply register; self clearing.
// - Bit 5 set compares all 64 wake-time bits, else only the low word.
// - Bit 4 set wakes the device when the timer reaches the wake time.
// - Bit 2 enables pin wake; bit 3 picks polarity, 1 high, resets to 1.
// - Writing 1 to bit 1 starts the sleep sequence; the bit self clears.
// - Bit 0 picks sleep clock: 0 internal oscillator, 1 default; asleep only.
// - Offset 0x04 holds wake-time low word, read-write, reset 0, used asleep.
// - Offset 0x08 holds wake-time high word, used only in 64-bit timer wake.
// - Awake supply bit 14 gates off the processor tile clock; resets 0.
// - Awake supply bit 9 picks analogue converter modulation, 0 PWM, 1 PFM.
// - Awake supply bit 8 picks core converter modulation, 0 PWM, 1 PFM.
// - Awake supply bits 5, 4, 0 enable IO, PLL regulator, core converter; reset 1.
// - Awake supply bit 1, analogue converter enable, is read-only and reads 1.
// - Offset 0x1C sets first sleeping state supplies and its dwell time.
// - Status bits 29, 28, 25 report IO, PLL, analogue enables of previous state.
// - Status bits 18:16 report the sequencer state code 0 to 7.
module swpc_sequencer (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic [31:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [31:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [63:0] TIMER_VALUE,
  input wire logic WAKE_PIN,
  output swpc_pkg::swpc_supply_t SUPPLY,
  output logic SLEEP_CLK_DEFAULT,
  output logic USB_SUSPEND_POWER_UP_EN,
  output logic USB_SUSPEND_POWER_DOWN_EN,
  output logic WAKE_USE_POR_LEVELS,
  output logic WAKE_LEVELS_APPLY,
  output logic [2:0] SEQ_STATE
);

  // AXI4-Lite write channel holding registers
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic wr_hit;

  // AXI4-Lite read channel
  logic rd_fire;
  logic rd_hit;
  logic [31:0] rd_value;

  // Software registers
  logic [31:0] ctl;
  logic [31:0] wake_low;
  logic [31:0] wake_high;
  logic [31:0] awake_sup;
  logic [31:0] sleep1_sup;
  logic reapply;
  logic sleep_go;

  // Sequencer
  swpc_pkg::swpc_state_t state;
  swpc_pkg::swpc_state_t next_state;
  logic [15:0] dwell;
  logic [15:0] next_dwell;
  logic [3:0] prev_en;
  logic pin_meta;
  logic pin_sync;
  logic pin_wake;
  logic timer_wake;
  swpc_pkg::swpc_supply_t awake_cfg;
  swpc_pkg::swpc_supply_t sleep1_cfg;

  // Byte-lane merge of a write into a register, keeping read-only bits
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb, input logic [31:0] mask);
    logic [31:0] lanes;
    lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & mask;
    return (old & ~lanes) | (data & lanes);
  endfunction

  // Map a supply register onto the applied configuration
  function automatic swpc_pkg::swpc_supply_t to_cfg(input logic [31:0] r);
    swpc_pkg::swpc_supply_t c;
    c.tile_clk_off = r[swpc_pkg::SUP_TILE_CLK_OFF];
    c.analogue_pfm = r[swpc_pkg::SUP_ANALOGUE_PFM];
    c.core_pfm = r[swpc_pkg::SUP_CORE_PFM];
    c.io_supply_output_en = r[swpc_pkg::SUP_IO_EN];
    c.pll_supply_regulator_en = r[swpc_pkg::SUP_PLL_EN];
    c.analogue_supply_converter_en = r[swpc_pkg::SUP_ANALOGUE_EN];
    c.core_supply_converter_en = r[swpc_pkg::SUP_CORE_EN];
    return c;
  endfunction

  assign awake_cfg = to_cfg(awake_sup);
  assign sleep1_cfg = to_cfg(sleep1_sup);

  // Address and data may arrive in either order; each is held until both are present
  assign S_AXI_AWREADY = !aw_held && !S_AXI_BVALID;
  assign S_AXI_WREADY = !w_held && !S_AXI_BVALID;
  assign wr_fire = aw_held && w_held && !S_AXI_BVALID;

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_held <= 1'b1;
      aw_addr <= S_AXI_AWADDR[7:0];
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_held <= 1'b1;
      w_data <= S_AXI_WDATA;
      w_strb <= S_AXI_WSTRB;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  always_comb begin
    case (aw_addr)
      swpc_pkg::OFS_CONTROL, swpc_pkg::OFS_WAKE_LOW, swpc_pkg::OFS_WAKE_HIGH,
      swpc_pkg::OFS_AWAKE_SUPPLY, swpc_pkg::OFS_SLEEP1_SUPPLY, swpc_pkg::OFS_STATUS: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // Write response; unmapped addresses answer SLVERR
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= 2'b00;
    end else if (wr_fire) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP <= wr_hit ? 2'b00 : 2'b10;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // General control: stored bits plus two one-cycle command strobes
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      ctl <= swpc_pkg::CTL_RESET;
    end else if (wr_fire && aw_addr == swpc_pkg::OFS_CONTROL) begin
      ctl <= merge(ctl, w_data, w_strb, swpc_pkg::CTL_RW_MASK);
    end
  end

  // Strobes never store, so bits 6 and 1 read back as zero
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      reapply <= 1'b0;
      sleep_go <= 1'b0;
    end else begin
      reapply <= wr_fire && aw_addr == swpc_pkg::OFS_CONTROL && w_strb[0] && w_data[swpc_pkg::CTL_REAPPLY];
      sleep_go <= wr_fire && aw_addr == swpc_pkg::OFS_CONTROL && w_strb[0] && w_data[swpc_pkg::CTL_SLEEP_GO];
    end
  end

  // Wake time words
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      wake_low <= 32'h0000_0000;
      wake_high <= 32'h0000_0000;
    end else if (wr_fire && aw_addr == swpc_pkg::OFS_WAKE_LOW) begin
      wake_low <= merge(wake_low, w_data, w_strb, 32'hffff_ffff);
    end else if (wr_fire && aw_addr == swpc_pkg::OFS_WAKE_HIGH) begin
      wake_high <= merge(wake_high, w_data, w_strb, 32'hffff_ffff);
    end
  end

  // Supply registers; the analogue enable bit is outside the writable mask
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      awake_sup <= swpc_pkg::AWAKE_RESET;
      sleep1_sup <= swpc_pkg::SLEEP1_RESET;
    end else if (wr_fire && aw_addr == swpc_pkg::OFS_AWAKE_SUPPLY) begin
      awake_sup <= merge(awake_sup, w_data, w_strb, swpc_pkg::AWAKE_RW_MASK);
    end else if (wr_fire && aw_addr == swpc_pkg::OFS_SLEEP1_SUPPLY) begin
      sleep1_sup <= merge(sleep1_sup, w_data, w_strb, swpc_pkg::SLEEP1_RW_MASK);
    end
  end

  // Read path: one address at a time, data registered the cycle after acceptance
  assign S_AXI_ARREADY = !S_AXI_RVALID;
  assign rd_fire = S_AXI_ARVALID && S_AXI_ARREADY;

  always_comb begin
    rd_hit = 1'b1;
    case (S_AXI_ARADDR[7:0])
      swpc_pkg::OFS_CONTROL: rd_value = ctl;
      swpc_pkg::OFS_WAKE_LOW: rd_value = wake_low;
      swpc_pkg::OFS_WAKE_HIGH: rd_value = wake_high;
      swpc_pkg::OFS_AWAKE_SUPPLY: rd_value = awake_sup;
      swpc_pkg::OFS_SLEEP1_SUPPLY: rd_value = sleep1_sup;
      swpc_pkg::OFS_STATUS: begin
        rd_value = 32'h0000_0000;
        rd_value[swpc_pkg::STA_PREV_IO] = prev_en[3];
        rd_value[swpc_pkg::STA_PREV_PLL] = prev_en[2];
        rd_value[swpc_pkg::STA_PREV_ANALOGUE] = prev_en[1];
        rd_value[swpc_pkg::STA_PREV_CORE] = prev_en[0];
        rd_value[swpc_pkg::STA_STATE_LSB +: 3] = state;
        rd_value[swpc_pkg::SUP_TILE_CLK_OFF] = SUPPLY.tile_clk_off;
        rd_value[swpc_pkg::SUP_ANALOGUE_PFM] = SUPPLY.analogue_pfm;
        rd_value[swpc_pkg::SUP_CORE_PFM] = SUPPLY.core_pfm;
        rd_value[swpc_pkg::SUP_IO_EN] = SUPPLY.io_supply_output_en;
        rd_value[swpc_pkg::SUP_PLL_EN] = SUPPLY.pll_supply_regulator_en;
        rd_value[swpc_pkg::SUP_ANALOGUE_EN] = SUPPLY.analogue_supply_converter_en;
        rd_value[swpc_pkg::SUP_CORE_EN] = SUPPLY.core_supply_converter_en;
      end
      default: begin
        rd_value = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= 2'b00;
    end else if (rd_fire) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= rd_value;
      S_AXI_RRESP <= rd_hit ? 2'b00 : 2'b10;
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

  // Wake pin synchroniser; only the second stage feeds logic
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
    end else begin
      pin_meta <= WAKE_PIN;
      pin_sync <= pin_meta;
    end
  end

  // Wake sources; >= so a timer that steps past the target still wakes
  assign pin_wake = ctl[swpc_pkg::CTL_PIN_WAKE] && (pin_sync == ctl[swpc_pkg::CTL_PIN_POL]);
  assign timer_wake = ctl[swpc_pkg::CTL_TIMER_WAKE] && (ctl[swpc_pkg::CTL_TIMER64] ?
                      (TIMER_VALUE >= {wake_high, wake_low}) :
                      (TIMER_VALUE[31:0] >= wake_low));

  // Sequencer transitions and dwell counting
  always_comb begin
    next_state = state;
    next_dwell = (dwell == 16'h0000) ? 16'h0000 : dwell - 16'h0001;
    case (state)
      swpc_pkg::ST_RESET: begin
        next_state = swpc_pkg::ST_AWAKE_WAIT;
        next_dwell = 16'(swpc_pkg::STEP_CYCLES - 1);
      end
      swpc_pkg::ST_AWAKE: begin
        if (sleep_go) begin
          next_state = swpc_pkg::ST_STATE_SLEEP_ENTRY_ONE;
          next_dwell = sleep1_sup[swpc_pkg::SUP_DWELL_LSB +: swpc_pkg::SUP_DWELL_W];
        end
      end
      swpc_pkg::ST_STATE_SLEEP_ENTRY_ONE: begin
        if (dwell == 16'h0000) begin
          next_state = swpc_pkg::ST_SLEEPING2;
          next_dwell = 16'(swpc_pkg::STEP_CYCLES - 1);
        end
      end
      swpc_pkg::ST_SLEEPING2: begin
        if (dwell == 16'h0000) begin
          next_state = swpc_pkg::ST_ASLEEP;
        end
      end
      swpc_pkg::ST_ASLEEP: begin
        if (pin_wake || timer_wake) begin
          next_state = swpc_pkg::ST_WAKING1;
          next_dwell = 16'(swpc_pkg::STEP_CYCLES - 1);
        end
      end
      swpc_pkg::ST_WAKING1: begin
        if (dwell == 16'h0000) begin
          next_state = swpc_pkg::ST_WAKING2;
          next_dwell = 16'(swpc_pkg::STEP_CYCLES - 1);
        end
      end
      swpc_pkg::ST_WAKING2: begin
        if (dwell == 16'h0000) begin
          next_state = swpc_pkg::ST_AWAKE_WAIT;
          next_dwell = 16'(swpc_pkg::STEP_CYCLES - 1);
        end
      end
      swpc_pkg::ST_AWAKE_WAIT: begin
        if (dwell == 16'h0000) begin
          next_state = swpc_pkg::ST_AWAKE;
        end
      end
      default: next_state = swpc_pkg::ST_RESET;
    endcase
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      state <= swpc_pkg::ST_RESET;
      dwell <= 16'h0000;
    end else begin
      state <= next_state;
      dwell <= next_dwell;
    end
  end

  // Enables in force just before each state change
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      prev_en <= 4'h2;
    end else if (next_state != state) begin
      prev_en <= {SUPPLY.io_supply_output_en, SUPPLY.pll_supply_regulator_en,
                  SUPPLY.analogue_supply_converter_en, SUPPLY.core_supply_converter_en};
    end
  end

  // Applied supplies: awake settings load on entering awake or on a re-apply
  // command; edits to the awake register alone do not disturb live rails
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      SUPPLY <= to_cfg(swpc_pkg::AWAKE_RESET);
    end else if (next_state == swpc_pkg::ST_STATE_SLEEP_ENTRY_ONE && state != swpc_pkg::ST_STATE_SLEEP_ENTRY_ONE) begin
      SUPPLY <= sleep1_cfg;
    end else if (next_state == swpc_pkg::ST_AWAKE && state != swpc_pkg::ST_AWAKE) begin
      SUPPLY <= awake_cfg;
    end else if (reapply && state == swpc_pkg::ST_AWAKE) begin
      SUPPLY <= awake_cfg;
    end
  end

  // Level choice is frozen at the start of each wake-up
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      WAKE_USE_POR_LEVELS <= 1'b0;
      WAKE_LEVELS_APPLY <= 1'b0;
    end else begin
      WAKE_LEVELS_APPLY <= (next_state == swpc_pkg::ST_WAKING1 && state == swpc_pkg::ST_ASLEEP);
      if (next_state == swpc_pkg::ST_WAKING1 && state == swpc_pkg::ST_ASLEEP) begin
        WAKE_USE_POR_LEVELS <= ctl[swpc_pkg::CTL_POR_LEVELS];
      end
    end
  end

  // Plain outputs from registers
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      SLEEP_CLK_DEFAULT <= 1'b1;
      USB_SUSPEND_POWER_UP_EN <= 1'b0;
      USB_SUSPEND_POWER_DOWN_EN <= 1'b0;
      SEQ_STATE <= 3'h0;
    end else begin
      SLEEP_CLK_DEFAULT <= (state == swpc_pkg::ST_ASLEEP) ? ctl[swpc_pkg::CTL_CLK_SEL] : 1'b1;
      USB_SUSPEND_POWER_UP_EN <= ctl[swpc_pkg::CTL_USB_UP];
      USB_SUSPEND_POWER_DOWN_EN <= ctl[swpc_pkg::CTL_USB_DOWN];
      SEQ_STATE <= state;
    end
  end

endmodule // swpc_sequencer

// ---- sim/swpc_sequencer_assertions.sv ----
/*
  Checker for the sleep and wake sequencer: state order, step lengths, sleep clock choice
  and register read-back. Assumes it is bound to swpc_sequencer and sees only its ports.
*/
module swpc_sequencer_assertions (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic [31:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic SLEEP_CLK_DEFAULT,
  input wire logic USB_SUSPEND_POWER_UP_EN,
  input wire logic USB_SUSPEND_POWER_DOWN_EN,
  input wire logic [2:0] SEQ_STATE
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  // Read taken this cycle; data follows one cycle later
  logic rd_take;
  assign rd_take = S_AXI_ARVALID && S_AXI_ARREADY;

  // State order around the sleep and wake loop
  property p_leave_awake;
    SEQ_STATE == 3'h5 ##1 SEQ_STATE != 3'h5 |-> SEQ_STATE == 3'h6;
  endproperty
  a_leave_awake: assert property (p_leave_awake) else $error("awake left to a wrong state");
  property p_leave_sleep2;
    SEQ_STATE == 3'h7 ##1 SEQ_STATE != 3'h7 |-> SEQ_STATE == 3'h1;
  endproperty
  a_leave_sleep2: assert property (p_leave_sleep2) else $error("second sleep step left wrongly");
  property p_leave_asleep;
    SEQ_STATE == 3'h1 ##1 SEQ_STATE != 3'h1 |-> SEQ_STATE == 3'h2;
  endproperty
  a_leave_asleep: assert property (p_leave_asleep) else $error("asleep left to a wrong state");

  // Fixed steps last ten cycles each
  property p_waking1_len;
    $changed(SEQ_STATE) && SEQ_STATE == 3'h2 |-> ##9 SEQ_STATE == 3'h2 ##1 SEQ_STATE == 3'h3;
  endproperty
  a_waking1_len: assert property (p_waking1_len) else $error("first waking step length wrong");
  property p_wait_len;
    $changed(SEQ_STATE) && SEQ_STATE == 3'h4 |-> ##9 SEQ_STATE == 3'h4 ##1 SEQ_STATE == 3'h5;
  endproperty
  a_wait_len: assert property (p_wait_len) else $error("awake wait length wrong");

  // Sleep clock choice only matters while asleep
  property p_clk_default;
    SEQ_STATE inside {3'h0, 3'h4, 3'h5} |-> SLEEP_CLK_DEFAULT;
  endproperty
  a_clk_default: assert property (p_clk_default) else $error("sleep clock switched while awake");

  // Self-clearing control bits never read back as set
  property p_self_clear;
    rd_take && S_AXI_ARADDR[7:0] == 8'h00 |=> !S_AXI_RDATA[6] && !S_AXI_RDATA[1];
  endproperty
  a_self_clear: assert property (p_self_clear) else $error("self clearing bit reads set");
  property p_usb_copy;
    rd_take && S_AXI_ARADDR[7:0] == 8'h00 |=>
      S_AXI_RDATA[9:8] == {USB_SUSPEND_POWER_UP_EN, USB_SUSPEND_POWER_DOWN_EN};
  endproperty
  a_usb_copy: assert property (p_usb_copy) else $error("USB suspend outputs differ from control");
  property p_analogue_ro;
    rd_take && S_AXI_ARADDR[7:0] == 8'h18 |=> S_AXI_RDATA[1];
  endproperty
  a_analogue_ro: assert property (p_analogue_ro) else $error("analogue enable reads clear");
endmodule // swpc_sequencer_assertions

bind swpc_sequencer swpc_sequencer_assertions u_chk (
  .CLK_SYS(CLK_SYS),
  .RST(RST),
  .S_AXI_ARADDR(S_AXI_ARADDR),
  .S_AXI_ARVALID(S_AXI_ARVALID),
  .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RDATA(S_AXI_RDATA),
  .SLEEP_CLK_DEFAULT(SLEEP_CLK_DEFAULT),
  .USB_SUSPEND_POWER_UP_EN(USB_SUSPEND_POWER_UP_EN),
  .USB_SUSPEND_POWER_DOWN_EN(USB_SUSPEND_POWER_DOWN_EN),
  .SEQ_STATE(SEQ_STATE)
);

// ---- sim/sleep_wake_power_control_bench.sv ----
/*
  Self-checking bench for the sleep and wake sequencer over AXI4-Lite.
  Assumes the checker is bound separately; the bench drives the timer and wake pin.
*/
module sleep_wake_power_control_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, pin = 1'b1;
  logic [63:0] tim = 64'h0000_0005_0000_0000;
  logic awready, wready, bvalid, arready, rvalid, clk_def, usb_up, usb_dn, por, lvl;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, aw_v, sl_v, w;
  logic [2:0] seq;
  swpc_pkg::swpc_supply_t supply;
  logic [65:0] q[$];
  int n_errors = 0, n_tests = 0, n_lvl = 0;

  swpc_sequencer dut (
    .CLK_SYS(clk), .RST(rst),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .TIMER_VALUE(tim), .WAKE_PIN(pin), .SUPPLY(supply), .SLEEP_CLK_DEFAULT(clk_def),
    .USB_SUSPEND_POWER_UP_EN(usb_up), .USB_SUSPEND_POWER_DOWN_EN(usb_dn),
    .WAKE_USE_POR_LEVELS(por), .WAKE_LEVELS_APPLY(lvl), .SEQ_STATE(seq)
  );

  always #50 clk = ~clk;

  // Free-running timer; wake times are set relative to it
  always @(posedge clk) tim <= tim + 64'h1;

  // Level-apply pulses, one per wake expected
  always @(posedge clk) if (lvl) n_lvl++;

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %0t ns: got %h, expected %h", $time, g, e);
    end
  endtask

  // Applied supplies in register bit order
  function automatic logic [31:0] sup(input logic [31:0] r);
    return {25'h0, r[14], r[9:8], r[5:4], r[1:0]};
  endfunction

  // Write: both channels offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
    q.push_back({r, 64'h0});
    @(posedge clk);
    awaddr <= {24'h0, a};
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // No cycle count assumed: only the watchdog ends a stuck wait
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask

  // Read: the expected word, masked, is noted for the monitor
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    logic ok;
    ok = a inside {swpc_pkg::OFS_CONTROL, swpc_pkg::OFS_WAKE_LOW, swpc_pkg::OFS_WAKE_HIGH,
                   swpc_pkg::OFS_AWAKE_SUPPLY, swpc_pkg::OFS_SLEEP1_SUPPLY, swpc_pkg::OFS_STATUS};
    q.push_back({ok ? 2'b00 : 2'b10, m, e & m});
    @(posedge clk);
    araddr <= {24'h0, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
  endtask

  // Bounded wait for a reported state
  task automatic wait_st(input logic [2:0] s, input int lim);
    int t;
    for (t = 0; t < lim && seq !== s; t++) @(posedge clk);
    chk({29'h0, seq}, {29'h0, s});
  endtask

  // Takes the oldest note at each response handshake
  always @(posedge clk) begin : mon
    logic [65:0] e;
    if ((bvalid && bready) || (rvalid && rready)) begin
      e = q.pop_front();
      chk({30'h0, rvalid ? rresp : bresp}, {30'h0, e[65:64]});
      if (rvalid) chk(rdata & e[63:32], e[31:0]);
    end
  end

  task automatic results();
    $display("errors %0d, checks %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Watchdog at 20000 cycles, well past the several hundred cycles the run needs
  initial begin
    #2000000;
    n_errors++;
    results();
  end

  initial begin
    void'($urandom(32'h3aea));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (20) @(posedge clk);
    // Reset values, state and supplies after leaving reset
    rd(8'h00, swpc_pkg::CTL_RESET, swpc_pkg::CTL_RW_MASK);
    rd(8'h04, 32'h0, 32'hffff_ffff);
    rd(8'h18, swpc_pkg::AWAKE_RESET, 32'h0000_4333);
    rd(8'h24, 32'h0005_0000, 32'h0007_0000);
    chk({25'h0, supply}, sup(swpc_pkg::AWAKE_RESET));
    // Unmapped offset: error response, nothing read
    wr(8'h40, 32'hffff_ffff, 4'hf, 2'b10);
    rd(8'h40, 32'h0, 32'hffff_ffff);
    // Byte lanes honoured on the wake-time low word; the high word is written whole
    w = $urandom;
    wr(8'h04, w, 4'h3, 2'b00);
    rd(8'h04, {16'h0, w[15:0]}, 32'hffff_ffff);
    wr(8'h08, w, 4'hf, 2'b00);
    rd(8'h08, w, 32'hffff_ffff);
    // Random control settings read back and reach the USB outputs
    repeat (4) begin
      w = $urandom & swpc_pkg::CTL_RW_MASK;
      wr(8'h00, w, 4'hf, 2'b00);
      rd(8'h00, w, swpc_pkg::CTL_RW_MASK);
      chk({30'h0, usb_up, usb_dn}, {30'h0, w[9:8]});
    end
    // New awake supplies wait for a re-apply
    aw_v = $urandom & 32'h0000_4331;
    wr(8'h18, aw_v, 4'hf, 2'b00);
    rd(8'h18, aw_v | 32'h2, 32'h0000_4333);
    chk({25'h0, supply}, sup(swpc_pkg::AWAKE_RESET));
    wr(8'h00, 32'h0000_0048, 4'hf, 2'b00);
    repeat (2) @(posedge clk);
    chk({25'h0, supply}, sup(aw_v | 32'h2));
    // Sleep, then wake on the low word although the high word is ahead
    sl_v = {16'h0003, 16'($urandom) & 16'h4333};
    wr(8'h1c, sl_v, 4'hf, 2'b00);
    rd(8'h1c, sl_v, 32'hffff_4333);
    wr(8'h08, 32'h0000_0006, 4'hf, 2'b00);
    w = tim[31:0] + 32'h0000_0180;
    wr(8'h04, w, 4'hf, 2'b00);
    // Sleep is only asked for from the awake state
    wr(8'h00, 32'h0000_001a, 4'hf, 2'b00);
    wait_st(3'h6, 8);
    repeat (2) @(posedge clk);
    chk({25'h0, supply}, sup(sl_v));
    wait_st(3'h1, 30);
    repeat (2) @(posedge clk);
    chk({31'h0, clk_def}, 32'h0);
    wait_st(3'h2, 500);
    chk({31'h0, (tim[31:0] - w) < 32'h8}, 32'h1);
    wait_st(3'h5, 40);
    repeat (2) @(posedge clk);
    chk({25'h0, supply}, sup(aw_v | 32'h2));
    chk({30'h0, por, n_lvl == 1}, 32'h1);
    rd(8'h24, {2'b0, sl_v[5:4], 2'b0, sl_v[1], 25'h0}, 32'h3200_0000);
    // Full 64-bit compare keeps it asleep; a low pin wakes it
    wr(8'h04, tim[31:0] + 32'h0000_0040, 4'hf, 2'b00);
    wr(8'h00, 32'h0000_00b7, 4'hf, 2'b00);
    wait_st(3'h1, 40);
    repeat (200) @(posedge clk);
    chk({29'h0, seq}, 32'h1);
    chk({31'h0, clk_def}, 32'h1);
    pin <= 1'b0;
    wait_st(3'h2, 12);
    pin <= 1'b1;
    wait_st(3'h5, 40);
    chk({30'h0, por, n_lvl == 2}, 32'h3);
    results();
  end
endmodule // sleep_wake_power_control_bench
